//--- hw/seem_pkg.sv
// Purpose: constants and types for the status event enable mask bank
// Assumes: one 40 MHz clock, masks written and read as 16-bit words
// Notes: bit positions are the mask bit numbers of each register set
`default_nettype none
package seem_pkg;
    localparam int unsigned MASK_W = 16;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    // writable positions per register
    localparam logic [15:0] MEAS_VALID = 16'h0238;
    localparam logic [15:0] QUES_VALID = 16'h0100;
    localparam logic [15:0] OPER_VALID = 16'h0078;
    // measurement bits
    localparam int unsigned MEAS_BUFFER_FULL_BIT = 9;
    localparam int unsigned MEAS_READING_AVAILABLE_BIT = 5;
    localparam int unsigned MEAS_PULSE_TRIGGER_TIMEOUT_BIT = 4;
    localparam int unsigned MEAS_READING_OVERFLOW_BIT = 3;
    // questionable bit
    localparam int unsigned QUES_CALIBRATION_BIT = 8;
    // operation bits
    localparam int unsigned OPER_POWER_SUPPLY_SHUTDOWN_BIT = 6;
    localparam int unsigned OPER_HEAT_SINK_SHUTDOWN_BIT = 5;
    localparam int unsigned OPER_CURRENT_LIMIT_TRIPPED_BIT = 4;
    localparam int unsigned OPER_CURRENT_LIMIT_ACTIVE_BIT = 3;
    // register selector codes
    typedef enum logic [1:0] {
        SEEM_SEL_MEAS = 2'h0,
        SEEM_SEL_QUES = 2'h1,
        SEEM_SEL_OPER = 2'h2
    } seem_sel_type;
    // host command carrier
    typedef struct packed {
        logic write;
        logic query;
        logic preset;
        seem_sel_type sel;
        logic [15:0] value;
    } seem_cmd_type;
    typedef struct packed {
        logic [15:0] meas;
        logic [15:0] ques;
        logic [15:0] oper;
    } seem_events_type;
endpackage
`default_nettype wire

//--- hw/seem_bank.sv
// Purpose: event enable masks gating events onto next-level summary bits
// Assumes: command parser hands over decoded binary values, one command a cycle
// Notes: summary and query outputs are registered, one cycle after cause
`default_nettype none
module seem_bank
    import seem_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // host command
    input wire seem_cmd_type cmd_in,
    // event registers of this level
    input wire seem_events_type events_in,
    // query answer
    output logic [15:0] query_data_out,
    output logic query_valid_out,
    // summaries to the next register set
    output logic meas_summary_out,
    output logic ques_summary_out,
    output logic oper_summary_out,
    // mask contents
    output logic [15:0] meas_mask_out,
    output logic [15:0] ques_mask_out,
    output logic [15:0] oper_mask_out
);
    // stored enable masks, one per register set
    logic [15:0] measurement_event_mask;
    logic [15:0] questionable_event_mask;
    logic [15:0] operation_event_mask;
    logic [15:0] next_meas;
    logic [15:0] next_ques;
    logic [15:0] next_oper;
    // write strobes decoded per register set
    logic meas_write;
    logic ques_write;
    logic oper_write;
    // query answer state
    logic [15:0] query_data;
    logic query_valid;
    logic [15:0] next_query_data;
    logic next_query_valid;
    // measurement events that pass their mask bit
    logic buffer_full_pass;
    logic reading_available_pass;
    logic pulse_trigger_timeout_pass;
    logic reading_overflow_pass;
    // questionable event that passes its mask bit
    logic calibration_pass;
    // operation events that pass their mask bit
    logic power_supply_shutdown_pass;
    logic heat_sink_shutdown_pass;
    logic current_limit_tripped_pass;
    logic current_limit_active_pass;
    // summary state
    logic meas_sum;
    logic ques_sum;
    logic oper_sum;
    logic next_meas_sum;
    logic next_ques_sum;
    logic next_oper_sum;

    // the whole value loads at once; positions with no event stay zero
    function automatic logic [15:0] load_mask(input logic [15:0] value,
            input logic [15:0] valid);
        load_mask = value & valid;
    endfunction

    // one event bit reaches the summary only through a set mask bit
    function automatic logic event_passes(input logic [15:0] ev, input logic [15:0] mask,
            input int unsigned pos);
        event_passes = ev[pos] & mask[pos];
    endfunction

    // stored value of the selected register, zero for the spare selector
    function automatic logic [15:0] pick_mask(input seem_sel_type sel,
            input logic [15:0] meas, input logic [15:0] ques, input logic [15:0] oper);
        case (sel)
            SEEM_SEL_MEAS: begin
                pick_mask = meas;
            end
            SEEM_SEL_QUES: begin
                pick_mask = ques;
            end
            SEEM_SEL_OPER: begin
                pick_mask = oper;
            end
            default: begin
                pick_mask = MASK_RESET;
            end
        endcase
    endfunction

    // write decode: a same-cycle preset wins, the spare selector is refused
    always_comb begin
        meas_write = 1'b0;
        ques_write = 1'b0;
        oper_write = 1'b0;
        if (cmd_in.write && !cmd_in.preset) begin
            case (cmd_in.sel)
                SEEM_SEL_MEAS: begin
                    meas_write = 1'b1;
                end
                SEEM_SEL_QUES: begin
                    ques_write = 1'b1;
                end
                SEEM_SEL_OPER: begin
                    oper_write = 1'b1;
                end
                default: begin
                    meas_write = 1'b0;
                end
            endcase
        end
    end

    // measurement mask: preset clears it, a write reloads every bit
    always_comb begin
        next_meas = measurement_event_mask;
        if (cmd_in.preset) begin
            next_meas = MASK_RESET;
        end else if (meas_write) begin
            next_meas = load_mask(cmd_in.value, MEAS_VALID);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            measurement_event_mask <= MASK_RESET;
        end else begin
            measurement_event_mask <= next_meas;
        end
    end

    // questionable mask: only the calibration position can be set
    always_comb begin
        next_ques = questionable_event_mask;
        if (cmd_in.preset) begin
            next_ques = MASK_RESET;
        end else if (ques_write) begin
            next_ques = load_mask(cmd_in.value, QUES_VALID);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            questionable_event_mask <= MASK_RESET;
        end else begin
            questionable_event_mask <= next_ques;
        end
    end

    // operation mask: preset clears it, a write reloads every bit
    always_comb begin
        next_oper = operation_event_mask;
        if (cmd_in.preset) begin
            next_oper = MASK_RESET;
        end else if (oper_write) begin
            next_oper = load_mask(cmd_in.value, OPER_VALID);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            operation_event_mask <= MASK_RESET;
        end else begin
            operation_event_mask <= next_oper;
        end
    end

    // query answer: reads see the value stored before a same-cycle write
    always_comb begin
        next_query_valid = cmd_in.query;
        next_query_data = MASK_RESET;
        if (cmd_in.query) begin
            next_query_data = pick_mask(cmd_in.sel, measurement_event_mask,
                questionable_event_mask, operation_event_mask);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            query_data <= MASK_RESET;
            query_valid <= 1'b0;
        end else begin
            query_data <= next_query_data;
            query_valid <= next_query_valid;
        end
    end

    // measurement summary; unused positions have no pass term at all
    always_comb begin
        buffer_full_pass = event_passes(
            events_in.meas,
            measurement_event_mask,
            MEAS_BUFFER_FULL_BIT
        );
        reading_available_pass = event_passes(
            events_in.meas,
            measurement_event_mask,
            MEAS_READING_AVAILABLE_BIT
        );
        pulse_trigger_timeout_pass = event_passes(
            events_in.meas,
            measurement_event_mask,
            MEAS_PULSE_TRIGGER_TIMEOUT_BIT
        );
        reading_overflow_pass = event_passes(
            events_in.meas,
            measurement_event_mask,
            MEAS_READING_OVERFLOW_BIT
        );
        next_meas_sum = buffer_full_pass
            | reading_available_pass
            | pulse_trigger_timeout_pass
            | reading_overflow_pass;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meas_sum <= 1'b0;
        end else begin
            meas_sum <= next_meas_sum;
        end
    end

    // questionable summary follows the calibration event alone
    always_comb begin
        calibration_pass = event_passes(
            events_in.ques,
            questionable_event_mask,
            QUES_CALIBRATION_BIT
        );
        next_ques_sum = calibration_pass;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ques_sum <= 1'b0;
        end else begin
            ques_sum <= next_ques_sum;
        end
    end

    // operation summary; a level that stays set keeps the summary up
    always_comb begin
        power_supply_shutdown_pass = event_passes(
            events_in.oper,
            operation_event_mask,
            OPER_POWER_SUPPLY_SHUTDOWN_BIT
        );
        heat_sink_shutdown_pass = event_passes(
            events_in.oper,
            operation_event_mask,
            OPER_HEAT_SINK_SHUTDOWN_BIT
        );
        current_limit_tripped_pass = event_passes(
            events_in.oper,
            operation_event_mask,
            OPER_CURRENT_LIMIT_TRIPPED_BIT
        );
        current_limit_active_pass = event_passes(
            events_in.oper,
            operation_event_mask,
            OPER_CURRENT_LIMIT_ACTIVE_BIT
        );
        next_oper_sum = power_supply_shutdown_pass
            | heat_sink_shutdown_pass
            | current_limit_tripped_pass
            | current_limit_active_pass;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            oper_sum <= 1'b0;
        end else begin
            oper_sum <= next_oper_sum;
        end
    end

    assign query_data_out = query_data;
    assign query_valid_out = query_valid;
    assign meas_summary_out = meas_sum;
    assign ques_summary_out = ques_sum;
    assign oper_summary_out = oper_sum;
    assign meas_mask_out = measurement_event_mask;
    assign ques_mask_out = questionable_event_mask;
    assign oper_mask_out = operation_event_mask;
endmodule
`default_nettype wire

//--- test/seem_bank_asserts.sv
// Purpose: port checks for the enable mask bank
// Assumes: one clock, async active-high reset
// Notes: summaries lag masks and events by one cycle
`default_nettype none
module seem_bank_asserts
    import seem_pkg::*;
(
    // clock, reset and inputs
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire seem_cmd_type cmd_in,
    input wire seem_events_type events_in,
    // outputs
    input wire logic [15:0] query_data_out,
    input wire logic query_valid_out,
    input wire logic meas_summary_out,
    input wire logic ques_summary_out,
    input wire logic oper_summary_out,
    input wire logic [15:0] meas_mask_out,
    input wire logic [15:0] ques_mask_out,
    input wire logic [15:0] oper_mask_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_meas; ##1 meas_summary_out == |($past(events_in.meas) & $past(meas_mask_out));
    endproperty
    a_meas: assert property (p_meas) else $error("meas summary wrong");
    property p_ques; ##1 ques_summary_out == |($past(events_in.ques) & $past(ques_mask_out));
    endproperty
    a_ques: assert property (p_ques) else $error("ques summary wrong");
    property p_oper; ##1 oper_summary_out == |($past(events_in.oper) & $past(oper_mask_out));
    endproperty
    a_oper: assert property (p_oper) else $error("oper summary wrong");
    property p_write; cmd_in.write && !cmd_in.preset && cmd_in.sel == SEEM_SEL_OPER
        |=> oper_mask_out == ($past(cmd_in.value) & OPER_VALID); endproperty
    a_write: assert property (p_write) else $error("mask load wrong");
    property p_preset; cmd_in.preset |=> {meas_mask_out, ques_mask_out, oper_mask_out} == '0;
    endproperty
    a_preset: assert property (p_preset) else $error("preset left a mask");
    property p_unused; (meas_mask_out & ~MEAS_VALID | ques_mask_out & ~QUES_VALID
        | oper_mask_out & ~OPER_VALID) == 16'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    property p_query; cmd_in.query && cmd_in.sel == SEEM_SEL_MEAS
        |=> query_valid_out && query_data_out == $past(meas_mask_out); endproperty
    a_query: assert property (p_query) else $error("query answer wrong");
    property p_hold; !cmd_in.write && !cmd_in.preset |=> $stable(meas_mask_out); endproperty
    a_hold: assert property (p_hold) else $error("mask changed");
endmodule
bind seem_bank seem_bank_asserts i_seem_bank_asserts (.*);
`default_nettype wire

//--- test/seem_host.sv
// Purpose: host side that sends enable commands
// Assumes: commands change at the falling edge
// Notes: a strobe stands one cycle, then a quiet cycle
`default_nettype none
module seem_host
    import seem_pkg::*;
(
    input wire logic core_clk_in,
    output var seem_cmd_type cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd_out = '0;
    // op is write, query, preset; value is the binary of the decimal parameter
    task automatic send(input logic [2:0] op, input logic [1:0] s, input logic [15:0] v);
        @(negedge core_clk_in);
        cmd_out = {op, s, v};
        @(negedge core_clk_in);
        cmd_out = '0;
    endtask
endmodule
`default_nettype wire

//--- test/tb_seem_bank.sv
// Purpose: self-checking bench for the enable mask bank
// Assumes: host model drives commands, bench drives events
// Notes: selector 3 writes are refused and read as zero
`default_nettype none
module tb_seem_bank
    import seem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic qv, ms, qs, os;
    logic [15:0] qd;
    logic [15:0] m [4] = '{default: 16'h0};
    seem_cmd_type cmd;
    seem_events_type ev = '0;
    int miscompares = 0, n_tests = 0, seed = 32'h37c0, cyc = 0;
    initial forever #12.5 core_clk_in = ~core_clk_in;
    seem_host i_seem_host (.core_clk_in(core_clk_in), .cmd_out(cmd));
    seem_bank i_seem_bank (.core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_in(cmd),
        .events_in(ev), .query_data_out(qd), .query_valid_out(qv), .meas_summary_out(ms),
        .ques_summary_out(qs), .oper_summary_out(os), .meas_mask_out(), .ques_mask_out(),
        .oper_mask_out());
    function automatic logic [15:0] keep(input logic [1:0] s, input logic [15:0] v);
        return s == 2'h0 ? v & MEAS_VALID : s == 2'h1 ? v & QUES_VALID :
            s == 2'h2 ? v & OPER_VALID : 16'h0;
    endfunction
    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic wq(input logic [1:0] s, input logic [15:0] v);
        i_seem_host.send(3'h4, s, v);
        m[s] = keep(s, v);
        ev = {16'($random(seed)), 32'($random(seed))};
        i_seem_host.send(3'h2, s, 16'h0);
        check(qv === 1'b1 && qd === m[s], "query");
        check({ms, qs, os} === {|(ev.meas & m[0]), |(ev.ques & m[1]),
            |(ev.oper & m[2])}, "summary");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // generous ceiling: the whole run needs about 200 cycles
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk_in);
        @(negedge core_clk_in) rst_in = 1'b0;
        wq(2'h2, 16'd24);
        for (int i = 0; i < 4; i++) wq(i[1:0], 16'hffff);
        $display("corner test done");
        repeat (40) wq(2'($random(seed)), 16'($random(seed)));
        $display("random test done");
        i_seem_host.send(3'h1, 2'h0, 16'h0);
        m = '{default: 16'h0};
        wq(2'h3, 16'hffff);
        $display("preset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
